// [inc/ivt_defines.svh]
`ifndef IVT_DEFINES_SVH
`define IVT_DEFINES_SVH

// ----------------------------------------------------------------------
// Sizes and levels
// ----------------------------------------------------------------------
`define IVT_NSRC 56
`define IVT_NPEC 8
`define IVT_NTRAP 9
`define IVT_LVL_MAX 4'hF

// ----------------------------------------------------------------------
// Trap numbers; the vector location is always four times the number
// ----------------------------------------------------------------------
`define IVT_TRAP_NMI 8'h02
`define IVT_TRAP_STKOF 8'h04
`define IVT_TRAP_STKUF 8'h06
`define IVT_TRAP_CLASS_B 8'h0A
`define IVT_TRAP_CC0 8'h10
`define IVT_TRAP_TMR 8'h20
`define IVT_TRAP_T7 8'h3D
`define IVT_TRAP_T2 8'h22
`define IVT_TRAP_S0TB 8'h47
`define IVT_TRAP_S0R 8'h2B
`define IVT_TRAP_PWM 8'h3F
`define IVT_TRAP_CC16 8'h30
`define IVT_TRAP_CC29 8'h44
`define IVT_TRAP_XP0 8'h40

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define IVT_REQ_LO 8'h00
`define IVT_REQ_HI 8'h04
`define IVT_EN_LO 8'h08
`define IVT_EN_HI 8'h0C
`define IVT_TFR 8'h10
`define IVT_STS 8'h14
`define IVT_MASK 8'h18
`define IVT_LVL 8'h1C

// ----------------------------------------------------------------------
// Event channel configuration fields and status bits
// ----------------------------------------------------------------------
`define IVT_PEC_WORD 8
`define IVT_PEC_INCDST 9
`define IVT_PEC_CONT 10
`define IVT_PEC_EN 11
`define IVT_EVT_TRAP 0
`define IVT_EVT_PECZ 1

`endif

// [inc/ivt_pkg.sv]
package ivt_pkg;
`include "ivt_defines.svh"

    typedef enum logic [1:0] {
        IVT_OFF_NONE = 2'b00,
        IVT_OFF_INT = 2'b01,
        IVT_OFF_TRAPA = 2'b10,
        IVT_OFF_TRAPB = 2'b11
    } ivt_kind_t;

    typedef struct packed {
        logic [`IVT_NSRC-1:0] req;
        logic [`IVT_NSRC-1:0] en;
        logic [`IVT_NSRC-1:0][3:0] prio;
        logic [`IVT_NPEC-1:0][17:0] pcfg;
        logic [`IVT_NPEC-1:0][31:0] pptr;
        logic [`IVT_NTRAP-1:0] trap_flag_register;
        logic [`IVT_NTRAP-1:0] tpend;
        logic in_a;
        logic in_b;
        logic rst_svc;
        logic [15:0] act;
        logic [1:0] sts;
        logic [1:0] msk;
        logic [31:0] prdata;
        ivt_kind_t off_kind;
        logic [5:0] off_idx;
        logic [3:0] off_prio;
        logic [7:0] off_trap;
        logic pec_valid;
        logic [2:0] pec_ch;
    } ivt_state_t;
endpackage

// [inc/ivt_if.sv]
`timescale 1ns/100ps
`include "ivt_defines.svh"
interface ivt_if;
    import ivt_pkg::*;
    logic [`IVT_NSRC-1:0] pend;
    logic [`IVT_NSRC-1:0][3:0] prio;
    logic win_valid;
    logic [5:0] win_idx;
    logic [3:0] win_prio;
    modport req (output pend, output prio, input win_valid, input win_idx, input win_prio);
    modport arb (input pend, input prio, output win_valid, output win_idx, output win_prio);
endinterface

// [logic/ivt_arb.sv]
`timescale 1ns/100ps
`include "ivt_defines.svh"
module ivt_arb
    import ivt_pkg::*;
(
    ivt_if.arb b
);
    // Ascending scan with a strict compare keeps the lowest index on a tie.
    always_comb
    begin
        b.win_valid = 1'b0;
        b.win_idx = 6'h00;
        b.win_prio = 4'h0;
        for (int i = 0; i < `IVT_NSRC; i++)
        begin
            if (b.pend[i] && (!b.win_valid || b.prio[i] > b.win_prio))
            begin
                b.win_valid = 1'b1;
                b.win_idx = 6'(i);
                b.win_prio = b.prio[i];
            end
        end
    end
endmodule // ivt_arb

// [logic/ivt_top.sv]
// Summary of operation
// - Every source has a request and enable flag and vectors to its fixed location and number.
// - Four shared extension vectors sit four bytes apart from 0100h to 010Ch, numbers 40h to 43h.
// - A hardware trap is taken at once, unmaskably, class A through its own vector, class B through the shared 0028h.
// - Each trap sets its own bit in the trap flag register.
// - A trap pre-empts everything except a trap service of the same or a higher class in progress.
// - During trap service no standard interrupt or event service is started.
// - Each source has a sixteen-level priority and nests only over strictly lower levels.
// - An event service moves one item, steps a pointer, counts down and interrupts at zero.
// - All class B traps share vector 0028h, number 0Ah, below resets and class A.
// - The CPU priority level reads fifteen while a reset or trap is serviced.
//
// Chosen here: the address map and the APB slave port.
`timescale 1ns/100ps
`include "ivt_defines.svh"
module ivt_top
    import ivt_pkg::*;
(
    input wire logic CLOCK_I,
    input wire logic RST_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [7:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    input wire logic [`IVT_NSRC-1:0] SRC_EVT_I,
    input wire logic [`IVT_NTRAP-1:0] TRAP_I,
    input wire logic VEC_ACK_I,
    input wire logic SVC_DONE_I,
    input wire logic PEC_ACK_I,
    output logic VEC_REQ_O,
    output logic [15:0] VEC_ADDR_O,
    output logic [7:0] VEC_TRAP_O,
    output logic PEC_REQ_O,
    output logic [15:0] PEC_SRC_O,
    output logic [15:0] PEC_DST_O,
    output logic PEC_WORD_O,
    output logic [3:0] CPU_PRIORITY_LEVEL_FIELD_O,
    output logic TRAP_BUSY_O,
    output logic IRQ_O
);
    ivt_state_t r;
    ivt_state_t next_r;
    ivt_if ab();
    logic [31:0] rd;
    logic [2:0] pw;
    logic [2:0] pc;
    logic in_prio;
    logic in_pec;
    logic mapped;
    logic [1:0] ev;
    logic [3:0] cpu_priority_level_field;
    logic [17:0] cfg;
    logic [15:0] step;
    logic pec_hit;
    logic [2:0] pec_sel;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [3:0] ivt_msb(input logic [15:0] v);
        logic [3:0] m;
        m = 4'h0;
        for (int i = 0; i < 16; i++)
        begin
            if (v[i])
                m = 4'(i);
        end
        return m;
    endfunction

    function automatic logic [7:0] ivt_trapno(input logic [5:0] i);
        logic [7:0] x;
        x = {2'b00, i};
        if (i < 6'h10)
            return `IVT_TRAP_CC0 + x;
        if (i < 6'h1D)
            return `IVT_TRAP_CC16 + x - 8'h10;
        if (i < 6'h20)
            return `IVT_TRAP_CC29 + x - 8'h1D;
        if (i >= 6'h34)
            return `IVT_TRAP_XP0 + x - 8'h34;
        if (i < 6'h22)
            return `IVT_TRAP_TMR + x - 8'h20;
        if (i < 6'h24)
            return `IVT_TRAP_T7 + x - 8'h22;
        if (i < 6'h2D)
            return `IVT_TRAP_T2 + x - 8'h24;
        if (i == 6'h2D)
            return `IVT_TRAP_S0TB;
        if (i == 6'h33)
            return `IVT_TRAP_PWM;
        return `IVT_TRAP_S0R + x - 8'h2E;
    endfunction

    assign ab.pend = r.req & r.en;
    assign ab.prio = r.prio;

    ivt_arb u_arb (
        .b(ab)
    );

    assign cpu_priority_level_field = (r.rst_svc || r.in_a || r.in_b) ? `IVT_LVL_MAX : ivt_msb(r.act);

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb
    begin
        next_r = r;
        ev = 2'b00;
        rd = 32'h0000_0000;
        mapped = 1'b1;
        cfg = 18'h0_0000;
        step = 16'h0000;
        pec_hit = 1'b0;
        pec_sel = 3'h0;
        pw = PADDR_I[4:2];
        pc = PADDR_I[5:3];
        in_prio = (PADDR_I[7:5] == 3'h1) && (pw != 3'h7) && (PADDR_I[1:0] == 2'h0);
        in_pec = (PADDR_I[7:6] == 2'h1) && (PADDR_I[1:0] == 2'h0);
        case (PADDR_I)
            `IVT_REQ_LO: rd = r.req[31:0];
            `IVT_REQ_HI: rd = {8'h00, r.req[55:32]};
            `IVT_EN_LO: rd = r.en[31:0];
            `IVT_EN_HI: rd = {8'h00, r.en[55:32]};
            `IVT_TFR: rd = {23'h00_0000, r.trap_flag_register};
            `IVT_STS: rd = {30'h0000_0000, r.sts};
            `IVT_MASK: rd = {30'h0000_0000, r.msk};
            `IVT_LVL: rd = {26'h000_0000, r.in_b, r.in_a, cpu_priority_level_field};
            default:
            begin
                if (in_prio)
                    rd = r.prio[{pw, 3'h0} +: 8];
                else if (in_pec)
                    rd = PADDR_I[2] ? r.pptr[pc] : {14'h0000, r.pcfg[pc]};
                else
                    mapped = 1'b0;
            end
        endcase
        // Read data is caught in the setup cycle so it stands in a flop.
        if (PSEL_I && !PENABLE_I && !PWRITE_I)
            next_r.prdata = rd;
        if (PSEL_I && PENABLE_I && PWRITE_I)
        begin
            case (PADDR_I)
                `IVT_REQ_LO: next_r.req[31:0] = PWDATA_I;
                `IVT_REQ_HI: next_r.req[55:32] = PWDATA_I[23:0];
                `IVT_EN_LO: next_r.en[31:0] = PWDATA_I;
                `IVT_EN_HI: next_r.en[55:32] = PWDATA_I[23:0];
                `IVT_TFR: next_r.trap_flag_register = r.trap_flag_register & ~PWDATA_I[8:0];
                `IVT_MASK: next_r.msk = PWDATA_I[1:0];
                default:
                begin
                    if (in_prio)
                        next_r.prio[{pw, 3'h0} +: 8] = PWDATA_I;
                    else if (in_pec && PADDR_I[2])
                        next_r.pptr[pc] = PWDATA_I;
                    else if (in_pec)
                        next_r.pcfg[pc] = PWDATA_I[17:0];
                end
            endcase
        end
        // Only bits that the read returned are cleared, so nothing is lost.
        if (PSEL_I && PENABLE_I && !PWRITE_I && PADDR_I == `IVT_STS)
            next_r.sts = r.sts & ~r.prdata[1:0];

        if (VEC_ACK_I)
        begin
            unique case (r.off_kind)
                IVT_OFF_INT:
                begin
                    next_r.req[r.off_idx] = 1'b0;
                    next_r.act[r.off_prio] = 1'b1;
                end
                IVT_OFF_TRAPA:
                begin
                    next_r.tpend[r.off_idx[1:0]] = 1'b0;
                    next_r.in_a = 1'b1;
                end
                IVT_OFF_TRAPB:
                begin
                    next_r.tpend[8:3] = 6'h00;
                    next_r.in_b = 1'b1;
                end
                IVT_OFF_NONE:
                begin
                end
            endcase
        end
        // Returns unwind the most recent service first.
        if (SVC_DONE_I)
        begin
            if (r.in_a)
                next_r.in_a = 1'b0;
            else if (r.in_b)
                next_r.in_b = 1'b0;
            else if (|r.act)
                next_r.act[ivt_msb(r.act)] = 1'b0;
        end
        if (PEC_ACK_I && r.pec_valid)
        begin
            cfg = r.pcfg[r.pec_ch];
            step = cfg[`IVT_PEC_WORD] ? 16'h0002 : 16'h0001;
            if (cfg[`IVT_PEC_INCDST])
                next_r.pptr[r.pec_ch][31:16] = r.pptr[r.pec_ch][31:16] + step;
            else
                next_r.pptr[r.pec_ch][15:0] = r.pptr[r.pec_ch][15:0] + step;
            if (!cfg[`IVT_PEC_CONT])
                next_r.pcfg[r.pec_ch][7:0] = cfg[7:0] - 8'h01;
            // At zero the channel hands its source back to a standard interrupt.
            if (!cfg[`IVT_PEC_CONT] && cfg[7:0] == 8'h01)
            begin
                next_r.pcfg[r.pec_ch][`IVT_PEC_EN] = 1'b0;
                ev[`IVT_EVT_PECZ] = 1'b1;
            end
            else
                next_r.req[cfg[17:12]] = 1'b0;
        end
        next_r.trap_flag_register = next_r.trap_flag_register | TRAP_I;
        next_r.tpend = next_r.tpend | TRAP_I;
        ev[`IVT_EVT_TRAP] = |TRAP_I;
        next_r.req = next_r.req | SRC_EVT_I;
        next_r.sts = next_r.sts | ev;
        next_r.rst_svc = 1'b0;

        for (int ch = 0; ch < `IVT_NPEC; ch++)
        begin
            if (!pec_hit && r.pcfg[ch][`IVT_PEC_EN] && r.pcfg[ch][17:12] == ab.win_idx
                && (r.pcfg[ch][`IVT_PEC_CONT] || r.pcfg[ch][7:0] != 8'h00))
            begin
                pec_hit = 1'b1;
                pec_sel = 3'(ch);
            end
        end
        // Offers are withdrawn for one cycle after any grant to avoid a repeat.
        next_r.off_kind = IVT_OFF_NONE;
        next_r.pec_valid = 1'b0;
        if (!VEC_ACK_I && !PEC_ACK_I && !r.rst_svc)
        begin
            // class A pre-empts all but class A
            if (|r.tpend[2:0] && !r.in_a)
            begin
                next_r.off_kind = IVT_OFF_TRAPA;
                next_r.off_idx = r.tpend[0] ? 6'h00 : (r.tpend[1] ? 6'h01 : 6'h02);
                next_r.off_trap = r.tpend[0] ? `IVT_TRAP_NMI :
                    (r.tpend[1] ? `IVT_TRAP_STKOF : `IVT_TRAP_STKUF);
            end
            else if (|r.tpend[8:3] && !r.in_a && !r.in_b)
            begin
                next_r.off_kind = IVT_OFF_TRAPB;
                next_r.off_trap = `IVT_TRAP_CLASS_B;
            end
            // only above the current level and outside trap service
            else if (!r.in_a && !r.in_b && ab.win_valid && ab.win_prio > cpu_priority_level_field)
            begin
                if (pec_hit)
                begin
                    next_r.pec_valid = 1'b1;
                    next_r.pec_ch = pec_sel;
                end
                else
                begin
                    next_r.off_kind = IVT_OFF_INT;
                    next_r.off_idx = ab.win_idx;
                    next_r.off_prio = ab.win_prio;
                    next_r.off_trap = ivt_trapno(ab.win_idx);
                end
            end
        end
    end

    always_ff @(posedge CLOCK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            r <= '0;
            r.rst_svc <= 1'b1;
        end
        else
            r <= next_r;
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign PRDATA_O = r.prdata;
    assign PREADY_O = 1'b1;
    assign PSLVERR_O = PSEL_I && PENABLE_I && !mapped;
    assign VEC_REQ_O = r.off_kind != IVT_OFF_NONE;
    assign VEC_TRAP_O = r.off_trap;
    assign VEC_ADDR_O = {6'h00, r.off_trap, 2'h0};
    assign PEC_REQ_O = r.pec_valid;
    assign PEC_SRC_O = r.pptr[r.pec_ch][15:0];
    assign PEC_DST_O = r.pptr[r.pec_ch][31:16];
    assign PEC_WORD_O = r.pcfg[r.pec_ch][`IVT_PEC_WORD];
    assign CPU_PRIORITY_LEVEL_FIELD_O = cpu_priority_level_field;
    assign TRAP_BUSY_O = r.in_a || r.in_b;
    assign IRQ_O = |(r.sts & r.msk);
endmodule // ivt_top

// [tb/ivt_core_model.sv]
`timescale 1ns/100ps
module ivt_core_model
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic hold_i,
    input wire logic vreq_i,
    input wire logic preq_i,
    input wire logic [7:0] vtrap_i,
    input wire logic [15:0] psrc_i,
    input wire logic [15:0] vaddr_i,
    input wire logic [15:0] pdst_i,
    input wire logic pword_i,
    output logic vack_o,
    output logic pack_o,
    output int cnt_o,
    output logic [7:0] trap_o,
    output logic [15:0] src_o,
    output logic [15:0] addr_o,
    output logic [15:0] dst_o,
    output logic word_o
);
    // Acks one cycle after an offer; hold_i plays a core that is slow to answer.
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            vack_o <= 1'b0;
            pack_o <= 1'b0;
            cnt_o <= 0;
            trap_o <= 8'h00;
            src_o <= 16'h0000;
            addr_o <= 16'h0000;
            dst_o <= 16'h0000;
            word_o <= 1'b0;
        end
        else
        begin
            vack_o <= vreq_i && !vack_o && !hold_i;
            pack_o <= preq_i && !pack_o && !hold_i;
            cnt_o <= cnt_o + int'(vreq_i && vack_o) + int'(preq_i && pack_o);
            if (vreq_i && vack_o)
            begin
                trap_o <= vtrap_i;
                addr_o <= vaddr_i;
            end
            if (preq_i && pack_o)
            begin
                src_o <= psrc_i;
                dst_o <= pdst_i;
                word_o <= pword_i;
            end
        end
    end
endmodule // ivt_core_model

// [tb/ivt_top_checker.sv]
`timescale 1ns/100ps
module ivt_top_checker
(
    input wire logic CLOCK_I,
    input wire logic RST_I,
    input wire logic [8:0] TRAP_I,
    input wire logic VEC_ACK_I,
    input wire logic VEC_REQ_O,
    input wire logic [15:0] VEC_ADDR_O,
    input wire logic [7:0] VEC_TRAP_O,
    input wire logic PEC_REQ_O,
    input wire logic [3:0] CPU_PRIORITY_LEVEL_FIELD_O,
    input wire logic TRAP_BUSY_O
);
    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (RST_I);
    property p_addr;
        VEC_REQ_O |-> VEC_ADDR_O == {6'h00, VEC_TRAP_O, 2'b00};
    endproperty
    a_addr: assert property (p_addr) else $error("vector address off");
    // The flag lands at the sampling edge, so the offer stands two edges later.
    property p_trap;
        TRAP_I[0] && !TRAP_BUSY_O && !VEC_REQ_O && !PEC_REQ_O
            |-> ##2 (VEC_REQ_O && VEC_TRAP_O == 8'h02);
    endproperty
    a_trap: assert property (p_trap) else $error("trap not offered");
    property p_busy;
        VEC_REQ_O && VEC_ACK_I && VEC_TRAP_O <= 8'h0A |=> TRAP_BUSY_O;
    endproperty
    a_busy: assert property (p_busy) else $error("trap not in service");
    property p_noint;
        TRAP_BUSY_O && VEC_REQ_O |-> VEC_TRAP_O <= 8'h0A;
    endproperty
    a_noint: assert property (p_noint) else $error("interrupt in trap");
    property p_nopec;
        TRAP_BUSY_O && $past(TRAP_BUSY_O) |-> !PEC_REQ_O;
    endproperty
    a_nopec: assert property (p_nopec) else $error("event service in trap");
    property p_nest;
        VEC_REQ_O && VEC_ACK_I && VEC_TRAP_O > 8'h0F |=> CPU_PRIORITY_LEVEL_FIELD_O > $past(CPU_PRIORITY_LEVEL_FIELD_O);
    endproperty
    a_nest: assert property (p_nest) else $error("level not raised");
    property p_classb;
        VEC_REQ_O && VEC_TRAP_O < 8'h10 |-> VEC_TRAP_O inside {8'h02, 8'h04, 8'h06, 8'h0A};
    endproperty
    a_classb: assert property (p_classb) else $error("bad trap number");
    property p_cpu_priority_level_field;
        TRAP_BUSY_O |-> CPU_PRIORITY_LEVEL_FIELD_O == 4'hF;
    endproperty
    a_cpu_priority_level_field: assert property (p_cpu_priority_level_field) else $error("level not fifteen");
    property p_take;
        VEC_REQ_O && VEC_ACK_I |=> !VEC_REQ_O;
    endproperty
    a_take: assert property (p_take) else $error("offer not withdrawn");
endmodule // ivt_top_checker

bind ivt_top ivt_top_checker i_chk (.CLOCK_I(CLOCK_I), .RST_I(RST_I), .TRAP_I(TRAP_I),
    .VEC_ACK_I(VEC_ACK_I), .VEC_REQ_O(VEC_REQ_O), .VEC_ADDR_O(VEC_ADDR_O),
    .VEC_TRAP_O(VEC_TRAP_O), .PEC_REQ_O(PEC_REQ_O), .CPU_PRIORITY_LEVEL_FIELD_O(CPU_PRIORITY_LEVEL_FIELD_O),
    .TRAP_BUSY_O(TRAP_BUSY_O));

// [tb/tb_top.sv]
`timescale 1ns/100ps
`include "ivt_defines.svh"
module tb_top;
    import ivt_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwd = 32'h0;
    logic [55:0] src = 56'h0;
    logic [8:0] trap = 9'h000;
    logic done = 1'b0;
    logic hold = 1'b0;
    logic vack, pack, vreq, preq, pword, busy, irq, prdy, perr, err;
    logic [31:0] prd, rd;
    logic [15:0] vaddr, psrc, pdst, lsrc;
    logic [15:0] laddr, ldst;
    logic lword;
    logic [7:0] vtrap, ltrap;
    logic [3:0] cpu_priority_level_field;
    int cnt, en;
    int failures = 0;
    int checks = 0;
    int idx [14] = '{0, 16, 28, 29, 34, 36, 41, 45, 46, 51, 52, 53, 54, 55};
    logic [7:0] tno [14] = '{8'h10, 8'h30, 8'h3C, 8'h44, 8'h3D, 8'h22, 8'h27, 8'h47, 8'h2B,
        8'h3F, 8'h40, 8'h41, 8'h42, 8'h43};
    always #20 clk = ~clk;
    ivt_top i_dut (.CLOCK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
        .PADDR_I(paddr), .PWDATA_I(pwd), .PRDATA_O(prd), .PREADY_O(prdy), .PSLVERR_O(perr),
        .SRC_EVT_I(src), .TRAP_I(trap), .VEC_ACK_I(vack), .SVC_DONE_I(done),
        .PEC_ACK_I(pack), .VEC_REQ_O(vreq), .VEC_ADDR_O(vaddr), .VEC_TRAP_O(vtrap),
        .PEC_REQ_O(preq), .PEC_SRC_O(psrc), .PEC_DST_O(pdst), .PEC_WORD_O(pword),
        .CPU_PRIORITY_LEVEL_FIELD_O(cpu_priority_level_field), .TRAP_BUSY_O(busy), .IRQ_O(irq));
    ivt_core_model i_core (.clk_i(clk), .rst_i(rst), .hold_i(hold), .vreq_i(vreq),
        .preq_i(preq), .vtrap_i(vtrap), .psrc_i(psrc), .vaddr_i(vaddr), .pdst_i(pdst),
        .pword_i(pword), .vack_o(vack), .pack_o(pack), .cnt_o(cnt), .trap_o(ltrap),
        .src_o(lsrc), .addr_o(laddr), .dst_o(ldst), .word_o(lword));
    task automatic wrap_up();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp)
        begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        // The slave may stretch the access; the wait ends when prdy is high or after 20 cycles.
        do
        begin
            @(posedge clk);
            k++;
        end
        while (prdy !== 1'b1 && k < 20);
        chk("pready", 32'h1, {31'h0, prdy});
        if (prdy !== 1'b1)
            wrap_up();
        rd = prd;
        err = perr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(what, exp, rd);
    endtask
    task automatic pulse(input logic [55:0] s, input logic [8:0] t);
        @(posedge clk);
        src <= s;
        trap <= t;
        @(posedge clk);
        src <= 56'h0;
        trap <= 9'h000;
    endtask
    task automatic ret();
        @(posedge clk);
        done <= 1'b1;
        @(posedge clk);
        done <= 1'b0;
        @(posedge clk);
    endtask
    task automatic take(input string what, input logic [7:0] exp);
        int k;
        en++;
        for (k = 0; k < 40 && cnt != en; k++)
            @(posedge clk);
        chk(what, exp, ltrap);
        if (cnt != en)
        begin
            failures++;
            $display("[FAIL] %s expected taken seen none", what);
            wrap_up();
        end
    endtask
    initial
    begin
        en = 0;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        rdchk("req", `IVT_REQ_LO, 32'h0);
        rdchk("trap_flags", `IVT_TFR, 32'h0);
        rdchk("level", `IVT_LVL, 32'h0);
        apb(1'b0, 8'h3C, 32'h0);
        chk("unmapped", 32'h1, {31'h0, err});
        $display("test reset done");
        apb(1'b1, `IVT_EN_LO, 32'hFFFFFFFF);
        apb(1'b1, `IVT_EN_HI, 32'h00FFFFFF);
        apb(1'b1, `IVT_MASK, 32'h00000003);
        for (int a = 8'h20; a <= 8'h38; a += 4)
            apb(1'b1, a[7:0], 32'h11111111);
        foreach (idx[i])
        begin
            pulse(56'h1 << idx[i], 9'h000);
            take("vector", tno[i]);
            chk("vec_addr", {22'h0, tno[i], 2'b00}, {16'h0, laddr});
            rdchk("level", `IVT_LVL, 32'h1);
            ret();
        end
        rdchk("req_lo", `IVT_REQ_LO, 32'h0);
        rdchk("req_hi", `IVT_REQ_HI, 32'h0);
        $display("test vectors done");
        hold <= 1'b1;
        pulse(56'h28, 9'h000);
        hold <= 1'b0;
        take("tie", 8'h13);
        repeat (6) @(posedge clk);
        chk("equal_refused", en, cnt);
        ret();
        take("second", 8'h15);
        ret();
        $display("test priority done");
        hold <= 1'b1;
        pulse(56'h2, 9'h009);
        repeat (2) @(posedge clk);
        chk("irq", 32'h1, {31'h0, irq});
        hold <= 1'b0;
        take("class_a", 8'h02);
        chk("trap_addr", 32'h0008, {16'h0, laddr});
        rdchk("level", `IVT_LVL, 32'h1F);
        rdchk("trap_flags", `IVT_TFR, 32'h9);
        rdchk("status", `IVT_STS, 32'h1);
        rdchk("status", `IVT_STS, 32'h0);
        chk("irq", 32'h0, {31'h0, irq});
        repeat (6) @(posedge clk);
        chk("blocked", en, cnt);
        ret();
        take("class_b", 8'h0A);
        chk("trap_addr", 32'h0028, {16'h0, laddr});
        rdchk("level", `IVT_LVL, 32'h2F);
        ret();
        take("after_traps", 8'h11);
        ret();
        apb(1'b1, `IVT_TFR, 32'h1FF);
        rdchk("trap_flags", `IVT_TFR, 32'h0);
        $display("test traps done");
        apb(1'b1, 8'h40, 32'h00007902);
        apb(1'b1, 8'h44, 32'h02000100);
        pulse(56'h80, 9'h000);
        take("pec1", 8'h11);
        chk("pec_src", 32'h0100, {16'h0, lsrc});
        chk("pec_dst", 32'h0200, {16'h0, ldst});
        chk("pec_word", 32'h1, {31'h0, lword});
        pulse(56'h80, 9'h000);
        take("pec2", 8'h11);
        chk("pec_src", 32'h0102, {16'h0, lsrc});
        take("pec_end", 8'h17);
        rdchk("status", `IVT_STS, 32'h2);
        rdchk("pec_cfg", 8'h40, 32'h00007100);
        ret();
        apb(1'b1, 8'h48, 32'h00009E00);
        apb(1'b1, 8'h4C, 32'h04000300);
        pulse(56'h200, 9'h000);
        take("pec_cont", 8'h17);
        chk("pec_src", 32'h0300, {16'h0, lsrc});
        chk("pec_dst", 32'h0400, {16'h0, ldst});
        chk("pec_word", 32'h0, {31'h0, lword});
        rdchk("pec_ptr", 8'h4C, 32'h04010300);
        rdchk("pec_cfg", 8'h48, 32'h00009E00);
        rdchk("req_lo", `IVT_REQ_LO, 32'h0);
        $display("test events done");
        wrap_up();
    end
endmodule // tb_top
